// [logic/sbt_timer.sv]
// Sixteen-bit timer/counter with a classic Wishbone register slave.
// Functional notes
// - The timer counts while the run bit is set and holds while it is clear.
// - With idle-halt set the timer stops in idle mode, otherwise it runs on.
// - The prescale field divides the input clock by 1, 8, 64 or 256.
// - With the external source, the sync bit selects the retimed pin edge and blocks count writes while running.
// - The source bit picks rising edges of the count pin or the core clock.
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`include "sbt_defs.svh"
module sbt_timer (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        externalCountPin,
  input  wire logic        gateInput,
  input  wire logic        idleMode,
  output logic             periodMatch
);

  sbt_pkg::sbt_ctrl_type ctrl;
  logic [15:0] control_q;
  logic [15:0] count_q;
  logic [15:0] period_q;
  logic        matchSticky_q;
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        match_q;
  logic        pinMeta_q;
  logic        pinSync_q;
  logic        pinPrev_q;
  logic        syncEdge_q;
  logic        rawEdge;
  logic        pinEdge;
  logic        gateMeta_q;
  logic        gateSync_q;
  logic        idleMeta_q;
  logic        idleSync_q;
  logic        active;
  logic        baseTick;
  logic        tick;
  logic        access;
  logic        wrEn;
  logic        hitControl;
  logic        hitCount;
  logic        hitPeriod;
  logic        hitStatus;
  logic        countWriteBlocked;
  logic [15:0] wlow;
  logic [15:0] ctrlWrite;

  // =====================================================================
  // Control field view
  // =====================================================================
  assign ctrl.run         = control_q[`SBT_BIT_RUN];
  assign ctrl.idleHalt    = control_q[`SBT_BIT_IDLEHALT];
  assign ctrl.gateEnable  = control_q[`SBT_BIT_GATE];
  assign ctrl.prescale    = control_q[`SBT_BIT_PSHI:`SBT_BIT_PSLO];
  assign ctrl.syncSelect  = control_q[`SBT_BIT_SYNC];
  assign ctrl.clockSource = control_q[`SBT_BIT_SRC];

  // =====================================================================
  // Input synchronisers
  // =====================================================================
  // Two flops per asynchronous input; only the second flop feeds logic.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pinMeta_q  <= 1'b0;
      pinSync_q  <= 1'b0;
      pinPrev_q  <= 1'b0;
      gateMeta_q <= 1'b0;
      gateSync_q <= 1'b0;
      idleMeta_q <= 1'b0;
      idleSync_q <= 1'b0;
    end else begin
      pinMeta_q  <= externalCountPin;
      pinSync_q  <= pinMeta_q;
      pinPrev_q  <= pinSync_q;
      gateMeta_q <= gateInput;
      gateSync_q <= gateMeta_q;
      idleMeta_q <= idleMode;
      idleSync_q <= idleMeta_q;
    end
  end

  // The synchronised path retimes the detected edge through one more flop,
  // so it reacts one cycle later; both paths read the second flop and pinPrev_q,
  // since a single-clock block cannot safely use the first one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      syncEdge_q <= 1'b0;
    end else begin
      syncEdge_q <= rawEdge;
    end
  end

  // =====================================================================
  // Tick selection
  // =====================================================================
  // Rising edge of the synchronised pin level.
  assign rawEdge = pinSync_q && !pinPrev_q;

  // The sync bit picks the retimed edge or the direct one.
  always_comb begin
    if (ctrl.syncSelect) begin
      pinEdge = syncEdge_q;
    end else begin
      pinEdge = rawEdge;
    end
  end

  // Run bit and idle halt decide whether anything advances.
  assign active = ctrl.run && !(ctrl.idleHalt && idleSync_q);

  // Source choice and gating; the gate only applies to the internal clock.
  always_comb begin
    if (ctrl.clockSource) begin
      baseTick = active && pinEdge;
    end else if (ctrl.gateEnable) begin
      baseTick = active && gateSync_q;
    end else begin
      baseTick = active;
    end
  end

  sbt_prescaler #(
    .WIDTH (8)
  ) u_prescaler (
    .clk     (clk),
    .rst     (rst),
    .clear   (!ctrl.run),
    .tickIn  (baseTick),
    .select  (ctrl.prescale),
    .tickOut (tick)
  );

  // =====================================================================
  // Wishbone decode
  // =====================================================================
  assign access     = wb_cyc_i && wb_stb_i && !ack_q;
  assign wrEn       = access && wb_we_i;
  assign hitControl = wb_adr_i == `SBT_OFF_CONTROL;
  assign hitCount   = wb_adr_i == `SBT_OFF_COUNT;
  assign hitPeriod  = wb_adr_i == `SBT_OFF_PERIOD;
  assign hitStatus  = wb_adr_i == `SBT_OFF_STATUS;
  assign countWriteBlocked = ctrl.run && ctrl.clockSource
                             && ctrl.syncSelect;

  // Byte lanes 0 and 1 carry the sixteen-bit registers.
  always_comb begin
    wlow = 16'h0000;
    wlow[7:0]  = wb_dat_i[7:0];
    wlow[15:8] = wb_dat_i[15:8];
  end

  // Unimplemented control bits are masked so that they always read zero.
  assign ctrlWrite = wlow & `SBT_CONTROL_MASK;

  // Control register; unimplemented bits stay zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      control_q <= `SBT_CONTROL_RST;
    end else if (wrEn && hitControl) begin
      if (wb_sel_i[0]) begin
        control_q[7:0] <= ctrlWrite[7:0];
      end
      if (wb_sel_i[1]) begin
        control_q[15:8] <= ctrlWrite[15:8];
      end
    end
  end

  // Period register sets where the count wraps to zero.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      period_q <= `SBT_PERIOD_RST;
    end else if (wrEn && hitPeriod) begin
      if (wb_sel_i[0]) begin
        period_q[7:0] <= wlow[7:0];
      end
      if (wb_sel_i[1]) begin
        period_q[15:8] <= wlow[15:8];
      end
    end
  end

  // =====================================================================
  // Counter
  // =====================================================================
  // A software write takes priority over a tick in the same cycle, so the
  // written value is stored rather than lost; it is ignored while run, source and sync are all set.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= `SBT_COUNT_RST;
    end else if (wrEn && hitCount && !countWriteBlocked) begin
      if (wb_sel_i[0]) begin
        count_q[7:0] <= wlow[7:0];
      end
      if (wb_sel_i[1]) begin
        count_q[15:8] <= wlow[15:8];
      end
    end else if (tick) begin
      if (count_q == period_q) begin
        count_q <= 16'h0000;
      end else begin
        count_q <= count_q + 16'h0001;
      end
    end
  end

  // Period match pulse and sticky flag; a new match beats a clear.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      match_q       <= 1'b0;
      matchSticky_q <= 1'b0;
    end else begin
      match_q <= tick && (count_q == period_q);
      if (tick && (count_q == period_q)) begin
        matchSticky_q <= 1'b1;
      end else if (wrEn && hitStatus && wb_sel_i[0] && wb_dat_i[0]) begin
        matchSticky_q <= 1'b0;
      end
    end
  end

  assign periodMatch = match_q;

  // =====================================================================
  // Read data and acknowledge
  // =====================================================================
  // One-cycle answer; unmapped addresses read zero and are acknowledged.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q <= access;
      if (access && !wb_we_i) begin
        unique case (1'b1)
          hitControl: rdata_q <= {16'h0000, control_q};
          hitCount:   rdata_q <= {16'h0000, count_q};
          hitPeriod:  rdata_q <= {16'h0000, period_q};
          hitStatus:  rdata_q <= {29'h0, active, idleSync_q, matchSticky_q};
          default:    rdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

endmodule : sbt_timer

// [include/sbt_defs.svh]
// Register offsets, field positions, reset values and constants for the timer.
`ifndef SBT_DEFS_SVH
`define SBT_DEFS_SVH

`define SBT_OFF_CONTROL  32'h0000_0000
`define SBT_OFF_COUNT    32'h0000_0004
`define SBT_OFF_PERIOD   32'h0000_0008
`define SBT_OFF_STATUS   32'h0000_000c

`define SBT_BIT_RUN      15
`define SBT_BIT_IDLEHALT 13
`define SBT_BIT_GATE     6
`define SBT_BIT_PSHI     5
`define SBT_BIT_PSLO     4
`define SBT_BIT_SYNC     2
`define SBT_BIT_SRC      1

`define SBT_CONTROL_MASK 16'ha076
`define SBT_CONTROL_RST  16'h0000
`define SBT_COUNT_RST    16'h0000
`define SBT_PERIOD_RST   16'hffff

`define SBT_PS_1         2'h0
`define SBT_PS_8         2'h1
`define SBT_PS_64        2'h2
`define SBT_PS_256       2'h3

`define SBT_DIV_8        8'h07
`define SBT_DIV_64       8'h3f
`define SBT_DIV_256      8'hff

`endif

// [include/sbt_pkg.sv]
// Types shared by the timer design files.
package sbt_pkg;

  typedef struct packed {
    logic       run;
    logic       idleHalt;
    logic       gateEnable;
    logic [1:0] prescale;
    logic       syncSelect;
    logic       clockSource;
  } sbt_ctrl_type;

  typedef struct packed {
    logic        adr;
    logic [31:0] dat;
  } sbt_unused_type;

endpackage : sbt_pkg

// [logic/sbt_prescaler.sv]
// Input prescaler: turns tick pulses into divided tick pulses.
`timescale 1ns/1ps
`include "sbt_defs.svh"
module sbt_prescaler #(
  parameter int WIDTH = 8
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic       tickIn,
  input  wire logic [1:0] select,
  output logic            tickOut
);

  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] limit;

  // =====================================================================
  // Division ratio
  // =====================================================================
  // Terminal value for the chosen ratio; 1:1 passes every tick.
  always_comb begin
    unique case (select)
      `SBT_PS_8:   limit = WIDTH'(`SBT_DIV_8);
      `SBT_PS_64:  limit = WIDTH'(`SBT_DIV_64);
      `SBT_PS_256: limit = WIDTH'(`SBT_DIV_256);
      default:     limit = '0;
    endcase
  end

  // Counts input ticks and emits one tick at the terminal value.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
    end else if (clear) begin
      count_q <= '0;
    end else if (tickIn) begin
      if (count_q >= limit) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + WIDTH'(1);
      end
    end
  end

  assign tickOut = tickIn && (count_q >= limit);

endmodule : sbt_prescaler

// [testbench/sbt_timer_properties.sv]
// Concurrent checks on the timer's bus and count outputs.
`timescale 1ns/1ps
module sbt_timer_checker (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic        externalCountPin,
  input wire logic        gateInput,
  input wire logic        idleMode,
  input wire logic        periodMatch
);
  // ==================================================================
  // Control shadow
  logic [15:0] ctrlQ;
  logic        runQ;
  // The shadow lags the design by one edge, which makes a_stop_no_match stricter after a start and looser after a stop.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrlQ <= 16'h0000;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == 32'h0) begin
      if (wb_sel_i[0]) ctrlQ[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrlQ[15:8] <= wb_dat_i[15:8];
    end
  end
  assign runQ = ctrlQ[15];
  // ==================================================================
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence busReq;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence readAck;
    wb_ack_o && !wb_we_i;
  endsequence
  a_ack_follows_req: assert property (busReq |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_needs_req: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  a_unmapped_zero: assert property (readAck and wb_adr_i > 32'hc
    |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
  a_ctrl_readback: assert property (
    readAck and wb_adr_i == 32'h0 |-> wb_dat_o == {16'h0, ctrlQ & 16'ha076})
    else $error("control readback wrong");
  a_stop_no_match: assert property ((!runQ)[*5] |-> !periodMatch)
    else $error("match while stopped");
  a_gate_closed: assert property (
    (runQ && ctrlQ[6] && !ctrlQ[1] && !gateInput)[*8] |-> !periodMatch)
    else $error("match with gate closed");
  a_idle_halted: assert property (
    (runQ && ctrlQ[13] && idleMode)[*8] |-> !periodMatch)
    else $error("match while halted in idle");
endmodule : sbt_timer_checker

bind sbt_timer sbt_timer_checker i_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
  .externalCountPin, .gateInput, .idleMode, .periodMatch);

// [testbench/sbt_pin_source.sv]
// Behavioural clock source that drives the external count pin.
`timescale 1ns/1ps
module sbt_pin_source (
  output logic pinOut
);
  // The pin rests low between bursts, as a stopped source would.
  initial pinOut = 1'b0;
  // Each pulse gives one rising edge; halfNs sets prompt or slow pacing.
  task automatic burst(input int n, input int halfNs);
    repeat (n) begin
      #(halfNs) pinOut = 1'b1;
      #(halfNs) pinOut = 1'b0;
    end
  endtask : burst
endmodule : sbt_pin_source

// [testbench/sbt_timer_tb.sv]
// Self-checking bench for the timer through its register bus.
`timescale 1ns/1ps
module sbt_timer_tb;
  logic        clk, rst, cyc, stb, we, ack, gate, idle, pin, match;
  logic [31:0] adr, wdat, rdat;
  logic [3:0]  sel;
  logic [15:0] x, y, junk, n;
  int          fails, checks_done;
  logic [31:0] offs [4] = '{32'h0, 32'h4, 32'h8, 32'hc};
  logic [15:0] rstv [4] = '{16'h0, 16'h0, 16'hffff, 16'h0};

  sbt_timer i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .externalCountPin(pin),
    .gateInput(gate), .idleMode(idle), .periodMatch(match));
  sbt_pin_source i_src (.pinOut(pin));

  // ==================================================================
  // Clock and helpers
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One classic cycle; a missing ack ends the run rather than hanging.
  task automatic bus(input logic [31:0] ad, input logic w,
                     input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= 4'h3;
    adr <= ad;
    wdat <= {16'h0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      fails++;
      finish_test();
    end else begin
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
    end
  endtask : bus

  // Two count reads exactly s edges apart, so start latency cancels out.
  task automatic meas(input logic [15:0] ctl, input int s,
                      input logic [15:0] exp);
    bus(32'h0, 1'b1, ctl, junk);
    repeat (8) @(posedge clk);
    bus(32'h4, 1'b0, 16'h0, x);
    repeat (s - 3) @(posedge clk);
    bus(32'h4, 1'b0, 16'h0, y);
    chk(y - x, exp);
  endtask : meas

  // Counts match pulses over 16 edges once the new control has settled.
  task automatic pulses(input logic [15:0] ctl, output logic [15:0] c);
    bus(32'h0, 1'b1, ctl, junk);
    repeat (8) @(posedge clk);
    c = 16'h0000;
    repeat (16) begin
      @(posedge clk);
      if (match === 1'b1) begin
        c++;
      end
    end
  endtask : pulses

  // ==================================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    {cyc, stb, we, gate, idle} = 5'h00;
    adr = 32'h0;
    wdat = 32'h0;
    sel = 4'h3;
    fails = 0;
    checks_done = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++) begin
      bus(offs[i], 1'b0, 16'h0, y);
      chk(y, rstv[i]);
    end
    bus(32'h0, 1'b1, 16'hffff, junk);
    bus(32'h0, 1'b0, 16'h0, y);
    chk(y, 16'ha076);
    bus(32'h10, 1'b1, 16'hffff, junk);
    bus(32'h10, 1'b0, 16'h0, y);
    chk(y, 16'h0000);
    // Ascending divisors keep the prescaler phase inside the new range.
    for (int k = 0; k < 4; k++) begin
      meas(16'(16'h8000 | (k << 4)), 16 << (k * 3 - (k == 3)), 16'd16);
    end
    meas(16'h0000, 16, 16'd0);
    meas(16'h8040, 16, 16'd0);
    gate <= 1'b1;
    meas(16'h8040, 16, 16'd16);
    idle <= 1'b1;
    meas(16'ha000, 16, 16'd0);
    meas(16'h8000, 16, 16'd16);
    for (int k = 0; k < 4; k++) begin
      bus(32'h0, 1'b1, k[0] ? 16'h8006 : 16'h8002, junk);
      bus(32'h4, 1'b0, 16'h0, x);
      i_src.burst(10, k[1] ? 157 : 61);
      repeat (8) @(posedge clk);
      bus(32'h4, 1'b0, 16'h0, y);
      chk(y - x, 16'd10);
    end
    bus(32'h4, 1'b0, 16'h0, x);
    bus(32'h4, 1'b1, 16'h1234, junk);
    bus(32'h4, 1'b0, 16'h0, y);
    chk(y, x);
    bus(32'h0, 1'b1, 16'h8002, junk);
    bus(32'h4, 1'b1, 16'h1234, junk);
    bus(32'h4, 1'b0, 16'h0, y);
    chk(y, 16'h1234);
    // Short period: a match every fourth tick, then halted, stopped, gated.
    bus(32'h8, 1'b1, 16'h0003, junk);
    bus(32'h4, 1'b1, 16'h0000, junk);
    pulses(16'h8000, n);
    chk(n, 16'd4);
    bus(32'hc, 1'b0, 16'h0, y);
    chk(y, 16'h0007);
    pulses(16'ha000, n);
    chk(n, 16'd0);
    bus(32'hc, 1'b1, 16'h0001, junk);
    bus(32'hc, 1'b0, 16'h0, y);
    chk(y, 16'h0002);
    pulses(16'h0000, n);
    chk(n, 16'd0);
    gate <= 1'b0;
    pulses(16'h8040, n);
    chk(n, 16'd0);
    finish_test();
  end
endmodule : sbt_timer_tb
